// *** cspc_core.sv ***
// processing state, privilege level, stack pointer select and access space control
module cspc_core (
   input  wire logic                 clock_in,           // core clock
   input  wire logic                 srst_in,            // synchronous reset, high
   input  wire cspc_pkg::cspc_instr_t instr_in,          // instruction offered by sequencer
   input  wire logic                 pipe_busy_in,       // earlier instructions still executing
   input  wire cspc_pkg::cspc_frame_t frame_in,          // return frame contents
   input  wire logic                 exc_req_in,         // sequencer exception request
   input  wire logic                 exc_trace_in,       // that request is a trace
   input  wire logic                 handler_start_in,   // first handler instruction starts
   input  wire logic                 addr_error_in,      // internal address error
   input  wire logic                 bus_error_in,       // bus error pin
   input  wire logic                 int_req_in,         // interrupt request pin
   input  wire logic                 cycle_req_in,       // sequencer wants a bus cycle
   input  wire logic                 cycle_prog_in,      // that cycle is a program fetch
   input  wire logic                 stack_ref_in,       // that cycle is a stack reference
   input  wire logic                 sp_wr_in,           // write active stack pointer
   input  wire logic [31:0]          sp_wdata_in,        // value for the write
   output logic [3:0]                state_out,          // one-hot processing state
   output logic [15:0]               status_word_out,    // current status word
   output logic                      supervisor_out,     // effective supervisor level
   output logic                      sp_user_sel_out,    // user pointer serves stack
   output logic [31:0]               sp_rdata_out,       // active stack pointer
   output logic                      bus_cycle_out,      // bus cycle issued
   output logic [2:0]                access_space_code_out, // space code of the cycle
   output logic                      issue_out,          // instruction issued pulse
   output logic                      priv_violation_out, // privilege violation pulse
   output logic [2:0]                exc_cause_out,      // cause of latest entry
   output logic                      save_status_out,    // push status pulse
   output logic [15:0]               saved_status_out,   // status word to push
   output logic                      flush_out,          // pipeline flush pulse
   output logic                      restore_pc_out,     // restore counter pulse
   output logic                      restore_full_out,   // restore full state pulse
   output logic                      ext_reset_out       // external reset instruction pulse
);
   import cspc_pkg::*;

   //****************************************************************
   // pin synchronisers: bit0 bus error, bit1 interrupt
   //****************************************************************
   logic [1:0]  sync1_reg;                               // first stage, read by stage two only
   logic [1:0]  sync2_reg;                               // second stage
   logic [1:0]  sync3_reg;                               // third stage
   logic [1:0]  filt_reg;                                // accepted level
   wire  [1:0]  filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));

   // a change counts only once stages two and three agree
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
         sync3_reg <= 2'h0;
         filt_reg  <= 2'h0;
      end else begin
         sync1_reg <= {int_req_in, bus_error_in};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         filt_reg  <= filt_next;
      end
   end

   wire bus_err = filt_reg[0];                           // filtered bus error
   wire int_req = filt_reg[1];                           // filtered interrupt

   //****************************************************************
   // state and status registers
   //****************************************************************
   cspc_state_t state_reg;                               // processing state
   cspc_state_t state_next;                              // its next value
   logic [15:0] sw_reg;                                  // status word
   logic [15:0] sw_next;                                 // its next value
   logic        set_priv_reg;                            // privilege flag set is pending
   logic        ack_reg;                                  // issue or violation just given
   logic [31:0] ssp_reg;                                 // supervisor_stack_pointer
   logic [31:0] usp_reg;                                 // user_stack_pointer

   //****************************************************************
   // decode of the offered instruction
   //****************************************************************
   wire priv_flag   = sw_reg[SW_PRIV_BIT];
   wire in_normal   = (state_reg == ST_NORMAL);
   wire in_stopped  = (state_reg == ST_STOPPED);
   wire in_exc      = (state_reg == ST_EXCEPTION);
   wire in_halted   = (state_reg == ST_HALTED);
   // effective level: exception processing is always supervisor
   wire eff_super   = priv_flag | in_exc;
   wire kind_priv   = (instr_in.kind == IK_HALT_WAIT) |
                      (instr_in.kind == IK_EXT_RESET) |
                      (instr_in.kind == IK_SW_WRITE)  |
                      (instr_in.kind == IK_RETURN)    |
                      (instr_in.kind == IK_OTHER_PRV);
   wire offer       = instr_in.valid & in_normal & ~ack_reg;
   // sync waits until all earlier instructions have finished
   wire sync_wait   = (instr_in.kind == IK_SYNC) & pipe_busy_in;
   // user level may not run privileged work; supervisor runs all
   wire violate     = offer & kind_priv & ~priv_flag;
   wire seq_exc     = exc_req_in & in_normal;
   wire take_exc    = in_normal & (violate | seq_exc | int_req);
   wire do_issue    = offer & ~violate & ~sync_wait & ~seq_exc & ~int_req;
   wire is_halt     = do_issue & (instr_in.kind == IK_HALT_WAIT);
   wire is_swwr     = do_issue & (instr_in.kind == IK_SW_WRITE);
   wire is_ret      = do_issue & (instr_in.kind == IK_RETURN);
   wire is_xrst     = do_issue & (instr_in.kind == IK_EXT_RESET);
   // only trace or interrupt wake a stopped core; reset is srst_in itself
   wire wake        = in_stopped & ((exc_req_in & exc_trace_in) | int_req);
   wire fatal       = in_exc & (bus_err | addr_error_in);
   wire enter_exc   = take_exc | wake;

   // cause priority: violation, then sequencer, then interrupt
   wire [2:0] cause_next = violate                 ? EC_PRIV :
                           (exc_req_in & exc_trace_in) ? EC_TRACE :
                           exc_req_in              ? EC_SEQ :
                           EC_INTR;

   //****************************************************************
   // next state
   //****************************************************************
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_NORMAL: begin
            if (enter_exc) begin
               state_next = ST_EXCEPTION;
            end else if (is_halt) begin
               state_next = ST_STOPPED;
            end
         end
         ST_STOPPED: begin
            if (wake) begin
               state_next = ST_EXCEPTION;
            end
         end
         ST_EXCEPTION: begin
            // an error beats handler start in the same cycle
            if (fatal) begin
               state_next = ST_HALTED;
            end else if (handler_start_in & ~set_priv_reg) begin
               state_next = ST_NORMAL;
            end
         end
         ST_HALTED: begin
            state_next = ST_HALTED;
         end
         default: begin
            state_next = ST_HALTED;                      // illegal code halts the core
         end
      endcase
   end

   //****************************************************************
   // status word next value
   //****************************************************************
   always_comb begin
      sw_next = sw_reg;
      if (set_priv_reg) begin
         sw_next[SW_PRIV_BIT] = 1'b1;
      end else if (is_swwr) begin
         sw_next = instr_in.sw_value;
      end else if (is_ret) begin
         sw_next = frame_in.sw_saved;
      end
   end

   //****************************************************************
   // state, status word and handshake registers
   //****************************************************************
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_reg    <= ST_NORMAL;
         sw_reg       <= SW_RESET;
         set_priv_reg <= 1'b0;
         ack_reg      <= 1'b0;
      end else begin
         state_reg    <= state_next;
         sw_reg       <= sw_next;
         // the flag is set one edge after the copy is pushed
         set_priv_reg <= enter_exc;
         ack_reg      <= do_issue | violate;
      end
   end

   //****************************************************************
   // stack pointers
   //****************************************************************
   // user pointer whenever the effective level is user
   wire sp_user = ~eff_super;
   wire [31:0] sp_active = sp_user ? usp_reg : ssp_reg;

   // a write outside the halted state lands in the pointer that is active this cycle
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ssp_reg <= SP_RESET;
         usp_reg <= SP_RESET;
      end else if (sp_wr_in & ~in_halted) begin
         if (sp_user) begin
            usp_reg <= sp_wdata_in;
         end else begin
            ssp_reg <= sp_wdata_in;
         end
      end
   end

   //****************************************************************
   // bus cycle and access space code
   //****************************************************************
   // stopped and halted cores leave the bus idle
   wire cyc_next = cycle_req_in & (in_normal | in_exc);
   wire [2:0] asc_next = eff_super ? (cycle_prog_in ? ASC_SUP_PROG : ASC_SUP_DATA) :
                                     (cycle_prog_in ? ASC_USER_PROG : ASC_USER_DATA);
   wire stack_unused = stack_ref_in;                     // stack cycles share the data space

   //****************************************************************
   // registered outputs
   //****************************************************************
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         bus_cycle_out         <= 1'b0;
         access_space_code_out <= ASC_SUP_DATA;
         issue_out             <= 1'b0;
         priv_violation_out    <= 1'b0;
         exc_cause_out         <= EC_NONE;
         save_status_out       <= 1'b0;
         saved_status_out      <= SW_RESET;
         flush_out             <= 1'b0;
         restore_pc_out        <= 1'b0;
         restore_full_out      <= 1'b0;
         ext_reset_out         <= 1'b0;
         sp_rdata_out          <= SP_RESET;
         sp_user_sel_out       <= 1'b0;
         supervisor_out        <= 1'b1;
      end else begin
         bus_cycle_out         <= cyc_next;
         access_space_code_out <= cyc_next ? asc_next : access_space_code_out;
         issue_out             <= do_issue;
         priv_violation_out    <= violate;
         exc_cause_out         <= enter_exc ? cause_next : exc_cause_out;
         // pushed copy is the word before the flag is forced
         save_status_out       <= enter_exc;
         saved_status_out      <= enter_exc ? sw_reg : saved_status_out;
         flush_out             <= is_swwr | is_ret;
         restore_pc_out        <= is_ret;
         restore_full_out      <= is_ret & frame_in.error_frame;
         ext_reset_out         <= is_xrst;
         sp_rdata_out          <= (sp_wr_in & ~in_halted) ? sp_wdata_in : sp_active;
         sp_user_sel_out       <= sp_user & ~stack_unused | sp_user & stack_unused;
         // level output has its own flop, so no inverter sits after a register
         supervisor_out        <= ~sp_user;
      end
   end

   // mirrors of state, registered through the state flops
   assign state_out       = state_reg;
   assign status_word_out = sw_reg;

   //****************************************************************
   // assertions
   //****************************************************************
   a_sync_waits: assert property (@(posedge clock_in) disable iff (srst_in)
      (instr_in.kind == IK_SYNC && pipe_busy_in) |=> !issue_out)
      else $error("sync issued while earlier work busy");
   a_stop_no_bus: assert property (@(posedge clock_in) disable iff (srst_in)
      $past(state_reg == ST_STOPPED) && (state_reg == ST_STOPPED) |-> !bus_cycle_out)
      else $error("bus cycle while stopped");
   a_exc_holds: assert property (@(posedge clock_in) disable iff (srst_in)
      (in_exc && !handler_start_in && !fatal) |=> (state_reg == ST_EXCEPTION))
      else $error("left exception without handler start");
   a_fatal_halt: assert property (@(posedge clock_in) disable iff (srst_in)
      (in_exc && addr_error_in) |=> (state_reg == ST_HALTED))
      else $error("address error in exception did not halt");
   a_wake_only: assert property (@(posedge clock_in) disable iff (srst_in)
      (in_stopped && !int_req && !(exc_req_in && exc_trace_in)) |=> (state_reg == ST_STOPPED))
      else $error("stopped core woke without cause");
   a_space_code: assert property (@(posedge clock_in) disable iff (srst_in)
      cyc_next |=> (access_space_code_out[2] == $past(eff_super)))
      else $error("space code level wrong");
   a_user_viol: assert property (@(posedge clock_in) disable iff (srst_in)
      (offer && kind_priv && !priv_flag) |=> priv_violation_out && !issue_out ##1 (state_reg == ST_EXCEPTION))
      else $error("privileged instruction at user level not trapped");
   a_save_first: assert property (@(posedge clock_in) disable iff (srst_in)
      save_status_out |-> (saved_status_out == $past(sw_reg)) ##1 sw_reg[SW_PRIV_BIT])
      else $error("status save order wrong");
   a_flush_ret: assert property (@(posedge clock_in) disable iff (srst_in)
      is_ret |=> flush_out && restore_pc_out && (restore_full_out == $past(frame_in.error_frame)))
      else $error("return did not flush or restore");
   a_halt_final: assert property (@(posedge clock_in) disable iff (srst_in)
      in_halted |=> in_halted && !bus_cycle_out ##1 !bus_cycle_out)
      else $error("halted core issued a cycle");
   a_exc_space: assert property (@(posedge clock_in) disable iff (srst_in)
      (in_exc && cycle_req_in) |=> access_space_code_out[2])
      else $error("exception cycle not supervisor");
   a_exc_stack: assert property (@(posedge clock_in) disable iff (srst_in)
      in_exc |=> !sp_user_sel_out)
      else $error("exception used user pointer");
   a_sup_issue: assert property (@(posedge clock_in) disable iff (srst_in)
      (offer && priv_flag && !sync_wait && !seq_exc && !int_req) |=> issue_out)
      else $error("supervisor instruction withheld");
   a_user_stack: assert property (@(posedge clock_in) disable iff (srst_in)
      (sp_wr_in && !eff_super && !in_halted) |=> (usp_reg == $past(sp_wdata_in)))
      else $error("user write missed user pointer");

endmodule : cspc_core

// *** cspc_pkg.sv ***
// constants, types and encodings for the processing state and privilege controller
//****************************************************************
// Operation
// - sync instruction waits for earlier completion
// - halt instructions enter stopped, no bus cycles
// - exception state lasts until handler starts
// - bus or address error in exception halts
// - stopped resumes only on trace, interrupt, reset
// - separate stack pointers chosen by privilege flag
// - access space code follows privilege flag
// - exception state forces supervisor everywhere
// - supervisor runs all, user runs some
// - halt and external reset instructions privileged
// - status privilege writers are privileged instructions
// - user level stack references use user pointer
// - save status before setting privilege flag
// - status writes and return flush pipeline
// - short frame return restores status, counter
// - error frame return restores full state
// - user privileged attempt raises privilege violation
//****************************************************************
package cspc_pkg;

   //****************************************************************
   // status word layout and reset values
   //****************************************************************
   localparam int          SW_WIDTH      = 16;           // status word width
   localparam int          SW_PRIV_BIT   = 13;           // privilege flag position
   localparam logic [15:0] SW_RESET      = 16'h2000;     // supervisor after reset
   localparam int          SP_WIDTH      = 32;           // stack pointer width
   localparam logic [31:0] SP_RESET      = 32'h00000000; // both pointers after reset

   //****************************************************************
   // access space codes
   //****************************************************************
   localparam logic [2:0]  ASC_USER_DATA = 3'h1;         // user data space
   localparam logic [2:0]  ASC_USER_PROG = 3'h2;         // user program space
   localparam logic [2:0]  ASC_SUP_DATA  = 3'h5;         // supervisor data space
   localparam logic [2:0]  ASC_SUP_PROG  = 3'h6;         // supervisor program space

   //****************************************************************
   // processing states, one-hot
   //****************************************************************
   typedef enum logic [3:0] {
      ST_NORMAL    = 4'h1,                               // executing instructions
      ST_STOPPED   = 4'h2,                               // normal variant, bus idle
      ST_EXCEPTION = 4'h4,                               // exception processing
      ST_HALTED    = 4'h8                                // catastrophic failure
   } cspc_state_t;

   // instruction classes offered by the sequencer
   typedef enum logic [2:0] {
      IK_OTHER     = 3'h0,                               // unprivileged, no side effect here
      IK_SYNC      = 3'h1,                               // pipeline_sync_instruction
      IK_HALT_WAIT = 3'h2,                               // stop or low_power_halt_instruction
      IK_EXT_RESET = 3'h3,                               // external reset instruction
      IK_SW_WRITE  = 3'h4,                               // move/and_immediate/xor_immediate/or_immediate_to_status
      IK_RETURN    = 3'h5,                               // return_from_exception_instruction
      IK_OTHER_PRV = 3'h6                                // any other privileged instruction
   } cspc_kind_t;

   // exception cause reported on entry
   typedef enum logic [2:0] {
      EC_NONE      = 3'h0,                               // no exception
      EC_PRIV      = 3'h1,                               // privilege violation
      EC_TRACE     = 3'h2,                               // trace
      EC_INTR      = 3'h3,                               // interrupt pin
      EC_SEQ       = 3'h4                                // other sequencer exception
   } cspc_cause_t;

   // instruction offered for issue
   typedef struct packed {
      logic             valid;                           // offer stands
      cspc_kind_t       kind;                            // class of instruction
      logic [15:0]      sw_value;                        // new status word for writes
   } cspc_instr_t;

   // return frame information
   typedef struct packed {
      logic             error_frame;                     // frame from bus or address error
      logic [15:0]      sw_saved;                        // status word popped from stack
   } cspc_frame_t;

endpackage : cspc_pkg

// *** cspc_bus_model.sv ***
// bus partner: memory side that can fault a cycle with a bus error
module cspc_bus_model (
   input  wire logic clock_in,     // core clock
   input  wire logic bus_cycle_in, // cycle issued by the core
   input  wire logic err_cmd_in,   // bench asks for a faulted cycle
   output logic      bus_error_out // bus error pin, high
);
   timeunit 1ns;
   timeprecision 1ps;
   // pin low at time zero, before any cycle
   initial bus_error_out = 1'b0;
   // error rises on a cycle and holds, so the 3-flop pin sync sees it
   always @(posedge clock_in) begin
      bus_error_out <= err_cmd_in & (bus_error_out | bus_cycle_in);
   end
endmodule : cspc_bus_model

// *** tb_top.sv ***
// self-checking bench for the state and privilege controller
module tb_top;
   import cspc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_in, srst_in, busy, exc_req, hstart, int_req;   // drives
   logic        creq, cprog, sp_wr, err_cmd, bus_err, trace, aerr, xrst; // drives, except bus_err from the bus model and xrst from the core
   logic [31:0] sp_wdata, sp_rdata;                                  // stack data
   cspc_instr_t instr;                                               // offer
   cspc_frame_t frame;                                               // return frame
   logic [3:0]  state;                                               // one-hot state
   logic [15:0] sw, saved;                                           // status words
   logic [2:0]  asc, cause;                                          // codes
   logic        sup, usel, bcyc, iss, pv, ssave, flush, rpc, rfull;  // flags
   int          n_mismatch = 0, n_checks = 0;                        // counters
   cspc_core i_cspc_core (.clock_in(clock_in), .srst_in(srst_in), .instr_in(instr),
      .pipe_busy_in(busy), .frame_in(frame), .exc_req_in(exc_req), .exc_trace_in(trace),
      .handler_start_in(hstart), .addr_error_in(aerr), .bus_error_in(bus_err),
      .int_req_in(int_req), .cycle_req_in(creq), .cycle_prog_in(cprog), .stack_ref_in(1'b0),
      .sp_wr_in(sp_wr), .sp_wdata_in(sp_wdata), .state_out(state), .status_word_out(sw),
      .supervisor_out(sup), .sp_user_sel_out(usel), .sp_rdata_out(sp_rdata),
      .bus_cycle_out(bcyc), .access_space_code_out(asc), .issue_out(iss),
      .priv_violation_out(pv), .exc_cause_out(cause), .save_status_out(ssave),
      .saved_status_out(saved), .flush_out(flush), .restore_pc_out(rpc),
      .restore_full_out(rfull), .ext_reset_out(xrst));
   cspc_bus_model i_cspc_bus_model (.clock_in(clock_in), .bus_cycle_in(bcyc),
      .err_cmd_in(err_cmd), .bus_error_out(bus_err));
   //****
   // helpers
   //****
   // inputs move 1 ns after the edge so sampling never races
   task automatic tick; @(posedge clock_in); #1; endtask : tick
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // offer stands one edge, valid drops in the answer cycle
   task automatic offer(input cspc_kind_t k, input logic [15:0] v);
      instr = '{1'b1, k, v}; tick; instr.valid = 1'b0;
   endtask : offer
   task automatic do_reset; srst_in = 1'b1; repeat (4) tick; srst_in = 1'b0; endtask : do_reset
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   //****
   // scenarios
   //****
   // return to user, user stack, violation, then error inside exception
   task automatic t_return;
      frame = '{1'b1, 16'h0000}; offer(IK_RETURN, 16'h0000);
      chk("restore_full", rfull, 1'h1);
      chk("restore_pc", rpc, 1'h1);
      chk("flush", flush, 1'h1);
      chk("status", sw, 16'h0000);
      sp_wr = 1'b1; sp_wdata = 32'h00001234; tick; sp_wr = 1'b0; creq = 1'b1; tick; creq = 1'b0;
      chk("user_sel", usel, 1'h1);
      chk("sup", sup, 1'h0);
      chk("sp_rdata", sp_rdata, 32'h00001234);
      chk("user_code", asc, 3'h2);
      tick; offer(IK_HALT_WAIT, 16'h2000);
      chk("violation", pv, 1'h1);
      chk("no_issue", iss, 1'h0);
      chk("save", ssave, 1'h1);
      chk("saved", saved, 16'h0000);
      chk("sw_before", sw, 16'h0000);
      tick; chk("exc_state", state, 4'h4);
      chk("sw_after", sw, 16'h2000);
      chk("cause", cause, 3'h1);
      creq = 1'b1; tick; creq = 1'b0; chk("exc_code", asc, 3'h6);
      err_cmd = 1'b1; creq = 1'b1; tick; creq = 1'b0;
      for (int i = 0; i < 12 && state !== 4'h8; i++) tick;
      chk("halted", state, 4'h8);
      err_cmd = 1'b0; creq = 1'b1; tick; tick; chk("halt_bus", bcyc, 1'h0);
      creq = 1'b0; $display("t_return done");
   endtask : t_return
   // stop, bus stays idle, interrupt wakes, handler start ends exception
   task automatic t_stop;
      offer(IK_HALT_WAIT, 16'h2000); chk("stop_issue", iss, 1'h1);
      tick; chk("stopped", state, 4'h2);
      creq = 1'b1; tick; tick; creq = 1'b0; chk("stop_bus", bcyc, 1'h0);
      int_req = 1'b1;
      for (int i = 0; i < 12 && state !== 4'h4; i++) tick;
      int_req = 1'b0; chk("wake", state, 4'h4);
      chk("int_cause", cause, 3'h3);
      repeat (4) tick; chk("still_exc", state, 4'h4);
      hstart = 1'b1; tick; hstart = 1'b0; chk("handler", state, 4'h1);
      $display("t_stop done");
   endtask : t_stop
   // sync waits while earlier work is busy
   task automatic t_sync;
      busy = 1'b1; offer(IK_SYNC, 16'h2000); chk("sync_wait", iss, 1'h0);
      busy = 1'b0; tick; offer(IK_SYNC, 16'h2000); chk("sync_go", iss, 1'h1);
      tick; offer(IK_EXT_RESET, 16'h2000); chk("xrst", xrst, 1'h1);
      $display("t_sync done");
   endtask : t_sync
   // short frame return, trace wake, address error halt, sequencer entry
   task automatic t_trace;
      tick; frame = '{1'b0, 16'h2000}; offer(IK_RETURN, 16'h0000);
      chk("short_full", rfull, 1'h0);
      chk("short_pc", rpc, 1'h1);
      tick; offer(IK_HALT_WAIT, 16'h2000); exc_req = 1'b1; repeat (3) tick;
      chk("no_wake", state, 4'h2);
      trace = 1'b1; tick; trace = 1'b0; exc_req = 1'b0;
      chk("trace_wake", state, 4'h4);
      chk("trace_cause", cause, 3'h2);
      aerr = 1'b1; tick; aerr = 1'b0; chk("addr_halt", state, 4'h8);
      do_reset; exc_req = 1'b1; tick; exc_req = 1'b0;
      chk("seq_entry", state, 4'h4);
      chk("seq_cause", cause, 3'h4);
      chk("seq_save", ssave, 1'h1);
      $display("t_trace done");
   endtask : t_trace
   // clock and watchdog; the run needs well under 2 us
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial begin
      #20000; n_mismatch++; give_verdict;
   end
   initial begin
      {busy, exc_req, hstart, int_req, creq, sp_wr, err_cmd, trace, aerr} = '0;
      cprog = 1'b1; sp_wdata = '0; instr = '0; frame = '0;
      do_reset; chk("reset_state", state, 4'h1);
      chk("reset_sup", sw, 16'h2000);
      t_return; do_reset; t_stop; tick; t_sync; t_trace; give_verdict;
   end
endmodule : tb_top
